// File: logic/tpl_pkg.sv
package tpl_pkg;
   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int TPL_W = 16;          // torque command width
   localparam int TPL_AW = 8;          // register address width
   localparam int TPL_DW = 32;         // register data width
   localparam int TPL_GAIN_FRAC = 8;   // gain is signed 8.8 fixed point

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] TPL_CTRL_OFS = 8'h00;
   localparam logic [7:0] TPL_GAIN_OFS = 8'h04;
   localparam logic [7:0] TPL_BIAS_OFS = 8'h08;
   localparam logic [7:0] TPL_STAT_OFS = 8'h0C;
   localparam logic [7:0] TPL_HELD_OFS = 8'h10;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int TPL_CTRL_SRC_LSB = 0;     // two bits of source select
   localparam int TPL_CTRL_LATCH_BIT = 2;   // latch mode
   localparam int TPL_CTRL_STRB_BIT = 3;    // strobe source
   localparam int TPL_STAT_VALID_BIT = 0;   // held value present
   localparam int TPL_STAT_ACTIVE_BIT = 1;  // latching actually in force
   localparam int TPL_STAT_APPLIED_LSB = 16; // last applied command

   // ----------------------------------------
   // mode encodings
   // ----------------------------------------
   typedef enum logic [1:0] {TPL_SRC_NONE, TPL_SRC_SERIAL, TPL_SRC_ANALOG} tpl_src_t;
   typedef enum logic {TPL_NOT_LATCHED, TPL_LATCHED} tpl_latch_t;
   typedef enum logic {TPL_STRB_SERIAL, TPL_STRB_TERMINAL} tpl_strb_t;
   typedef enum logic {TPL_ST_EMPTY, TPL_ST_HELD} tpl_state_t;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [1:0] TPL_SRC_RST = 2'h0;
   localparam logic TPL_LATCH_RST = 1'b0;
   localparam logic TPL_STRB_RST = 1'b1;
   localparam logic [15:0] TPL_GAIN_RST = 16'h0100;  // unity
   localparam logic [15:0] TPL_BIAS_RST = 16'h0000;
   localparam logic [15:0] TPL_CMD_RST = 16'h0000;

   // ----------------------------------------
   // saturate a wide signed sum into a command
   // ----------------------------------------
   function automatic logic signed [15:0] tpl_sat(input logic signed [33:0] v);
      if (v > 34'sh0_0000_7FFF)
         return 16'sh7FFF;
      else if (v < -34'sh0_0000_8000)
         return -16'sh8000;
      else
         return v[15:0];
   endfunction
endpackage

// File: logic/tpl_edge.sv
`timescale 1ns/100ps
// rising edge finder for strobes and release
module tpl_edge
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // level in, pulse out
   input wire logic level,
   output logic rise
);
   logic prev_q;  // level one cycle back

   // remember the level; reset low so a high level at release counts once
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         prev_q <= 1'b0;
      else
         prev_q <= level;
   end

   // false-to-true transition only
   assign rise = level & ~prev_q;
endmodule

// File: logic/tpl_scale.sv
`timescale 1ns/100ps
// analog channel scaling: signed value times gain plus bias
module tpl_scale
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // operands
   input wire logic signed [tpl_pkg::TPL_W-1:0] raw,
   input wire logic signed [tpl_pkg::TPL_W-1:0] gain,
   input wire logic signed [tpl_pkg::TPL_W-1:0] bias,
   // result, one cycle later
   output logic signed [tpl_pkg::TPL_W-1:0] scaled_q
);
   import tpl_pkg::*;

   logic signed [31:0] prod;     // full product
   logic signed [31:0] shifted;  // back to integer units
   logic signed [33:0] sum;      // headroom for bias
   logic signed [15:0] scaled_d;

   // product kept full width so no bits drop before the shift
   assign prod = raw * gain;
   assign shifted = prod >>> TPL_GAIN_FRAC;
   assign sum = 34'(shifted) + 34'(bias);
   // clip rather than wrap: a wrapped torque would reverse direction
   assign scaled_d = tpl_sat(sum);

   // register the result to keep the multiplier off the long path
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         scaled_q <= TPL_CMD_RST;
      else
         scaled_q <= scaled_d;
   end
endmodule

// File: logic/tpl_latch.sv
`timescale 1ns/100ps
// Contract
// - selector picks none, serial or analog source
// - enabled source takes serial or analog command
// - apply command when regulator release asserts
// - analog command signed, scaled by gain, bias
// - latch mode setting, resets to not latched
// - source none makes latch mode irrelevant
// - latched mode captures on strobe rising edge
// - channel changes outside edge leave latch alone
// - strobe from serial or terminal logic input
// - latched mode applies held value at release
// - after apply, clear latch and held value
// - strobe source resets to terminal input
module tpl_latch
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [tpl_pkg::TPL_AW-1:0] reg_addr,
   input wire logic [tpl_pkg::TPL_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [tpl_pkg::TPL_DW-1:0] reg_rdata,
   // car controller channels
   input wire logic [tpl_pkg::TPL_W-1:0] serial_cmd,
   input wire logic serial_strobe,
   input wire logic [tpl_pkg::TPL_W-1:0] analog_cmd,
   input wire logic terminal_logic_input,
   // regulator side
   input wire logic reg_release,
   output logic [tpl_pkg::TPL_W-1:0] torque_prime_cmd,
   output logic torque_prime_apply,
   output logic torque_prime_held
);
   import tpl_pkg::*;

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   tpl_src_t torque_prime_source_sel_q;   // none, serial or analog
   tpl_latch_t torque_prime_latch_mode_q; // latched or not
   tpl_strb_t torque_prime_strobe_src_q;  // serial or terminal
   logic [TPL_W-1:0] torque_prime_gain_q; // analog multiplier
   logic [TPL_W-1:0] bias_q;              // analog offset

   // ----------------------------------------
   // latch state
   // ----------------------------------------
   tpl_state_t state_q;           // empty or holding a value
   tpl_state_t state_d;
   logic [TPL_W-1:0] held_q;      // captured command
   logic [TPL_W-1:0] held_d;
   logic [TPL_W-1:0] cmd_q;       // command presented to regulator
   logic [TPL_W-1:0] cmd_d;
   logic apply_q;                 // one-cycle apply pulse
   logic apply_d;
   logic [TPL_DW-1:0] rdata_q;    // read data, one cycle after strobe
   logic [TPL_DW-1:0] rdata_d;

   // ----------------------------------------
   // decode of the register port
   // ----------------------------------------
   wire hit_ctrl = reg_addr == TPL_CTRL_OFS;
   wire hit_gain = reg_addr == TPL_GAIN_OFS;
   wire hit_bias = reg_addr == TPL_BIAS_OFS;
   wire hit_stat = reg_addr == TPL_STAT_OFS;
   wire hit_held = reg_addr == TPL_HELD_OFS;
   wire wr_ctrl = reg_wr & hit_ctrl;
   wire wr_gain = reg_wr & hit_gain;
   wire wr_bias = reg_wr & hit_bias;

   // ----------------------------------------
   // channel selection
   // ----------------------------------------
   logic [TPL_W-1:0] analog_scaled; // scaled analog command

   // analog path is signed and goes through gain and bias
   tpl_scale u_scale
   (
      .clk(clk),
      .rstn(rstn),
      .raw(analog_cmd),
      .gain(torque_prime_gain_q),
      .bias(bias_q),
      .scaled_q(analog_scaled)
   );

   // none disables priming altogether
   wire src_on = torque_prime_source_sel_q != TPL_SRC_NONE;
   // live channel value picked by the source selector
   wire [TPL_W-1:0] chan_val = (torque_prime_source_sel_q == TPL_SRC_ANALOG) ?
                               analog_scaled : serial_cmd;
   // latching only counts while a source is chosen
   wire latch_on = src_on & (torque_prime_latch_mode_q == TPL_LATCHED);

   // ----------------------------------------
   // strobe and release edges
   // ----------------------------------------
   logic strobe_rise; // capture strobe rising edge
   logic rel_rise;    // regulator release rising edge

   // strobe source mux; switching source may look like an edge,
   // so software should change it only while idle
   wire strobe_lvl = (torque_prime_strobe_src_q == TPL_STRB_TERMINAL) ?
                     terminal_logic_input : serial_strobe;

   tpl_edge u_strobe_edge
   (
      .clk(clk),
      .rstn(rstn),
      .level(strobe_lvl),
      .rise(strobe_rise)
   );

   tpl_edge u_release_edge
   (
      .clk(clk),
      .rstn(rstn),
      .level(reg_release),
      .rise(rel_rise)
   );

   // capture happens only on the edge and only when latching is active
   wire capture = latch_on & strobe_rise;
   wire apply = src_on & rel_rise;

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // control word: source, latch mode, strobe source
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         torque_prime_source_sel_q <= tpl_src_t'(TPL_SRC_RST);
         torque_prime_latch_mode_q <= tpl_latch_t'(TPL_LATCH_RST);
         torque_prime_strobe_src_q <= tpl_strb_t'(TPL_STRB_RST);
      end
      else if (wr_ctrl)
      begin
         torque_prime_source_sel_q <= tpl_src_t'(reg_wdata[TPL_CTRL_SRC_LSB +: 2]);
         torque_prime_latch_mode_q <= tpl_latch_t'(reg_wdata[TPL_CTRL_LATCH_BIT]);
         torque_prime_strobe_src_q <= tpl_strb_t'(reg_wdata[TPL_CTRL_STRB_BIT]);
      end
   end

   // gain of the analog path
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         torque_prime_gain_q <= TPL_GAIN_RST;
      else if (wr_gain)
         torque_prime_gain_q <= reg_wdata[TPL_W-1:0];
   end

   // bias of the analog path
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         bias_q <= TPL_BIAS_RST;
      else if (wr_bias)
         bias_q <= reg_wdata[TPL_W-1:0];
   end

   // ----------------------------------------
   // latch and apply logic
   // ----------------------------------------
   // next state of the latch, the presented command and the pulse
   always_comb
   begin
      state_d = state_q;
      held_d = held_q;
      cmd_d = cmd_q;
      apply_d = 1'b0;
      case (state_q)
         TPL_ST_EMPTY:
         begin
            // nothing held; a latched release applies zero
            if (apply)
            begin
               cmd_d = latch_on ? TPL_CMD_RST : chan_val;
               apply_d = 1'b1;
            end
         end
         TPL_ST_HELD:
         begin
            if (apply)
            begin
               // held value wins over the live channel
               cmd_d = latch_on ? held_q : chan_val;
               apply_d = 1'b1;
               if (latch_on)
               begin
                  // used once, then forgotten
                  state_d = TPL_ST_EMPTY;
                  held_d = TPL_CMD_RST;
               end
            end
            else if (!latch_on)
            begin
               // latching turned off: stale value is dropped
               state_d = TPL_ST_EMPTY;
               held_d = TPL_CMD_RST;
            end
         end
         default:
         begin
            state_d = TPL_ST_EMPTY;
            held_d = TPL_CMD_RST;
         end
      endcase
      // a capture in the same cycle as the clear is kept, not lost;
      // the channel is sampled only here, so later changes do nothing
      if (capture)
      begin
         state_d = TPL_ST_HELD;
         held_d = chan_val;
      end
   end

   // latch flops; reset leaves nothing to apply
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= TPL_ST_EMPTY;
         held_q <= TPL_CMD_RST;
      end
      else
      begin
         state_q <= state_d;
         held_q <= held_d;
      end
   end

   // command and apply pulse flops
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_q <= TPL_CMD_RST;
         apply_q <= 1'b0;
      end
      else
      begin
         cmd_q <= cmd_d;
         apply_q <= apply_d;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // read mux; unmapped addresses and idle cycles give zero
   always_comb
   begin
      rdata_d = '0;
      if (reg_rd)
      begin
         if (hit_ctrl)
         begin
            rdata_d[TPL_CTRL_SRC_LSB +: 2] = torque_prime_source_sel_q;
            rdata_d[TPL_CTRL_LATCH_BIT] = torque_prime_latch_mode_q;
            rdata_d[TPL_CTRL_STRB_BIT] = torque_prime_strobe_src_q;
         end
         else if (hit_gain)
            rdata_d[TPL_W-1:0] = torque_prime_gain_q;
         else if (hit_bias)
            rdata_d[TPL_W-1:0] = bias_q;
         else if (hit_stat)
         begin
            rdata_d[TPL_STAT_VALID_BIT] = state_q == TPL_ST_HELD;
            rdata_d[TPL_STAT_ACTIVE_BIT] = latch_on;
            rdata_d[TPL_STAT_APPLIED_LSB +: TPL_W] = cmd_q;
         end
         else if (hit_held)
            rdata_d[TPL_W-1:0] = held_q;
      end
   end

   // read data stand only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= '0;
      else
         rdata_q <= rdata_d;
   end

   // ----------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------
   assign reg_rdata = rdata_q;
   assign torque_prime_cmd = cmd_q;
   assign torque_prime_apply = apply_q;
   assign torque_prime_held = state_q == TPL_ST_HELD;
endmodule

// File: verification/tpl_latch_asserts.sv
`timescale 1ns/100ps
// port watcher for the torque priming latch
module tpl_latch_asserts
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [tpl_pkg::TPL_AW-1:0] reg_addr,
   input wire logic [tpl_pkg::TPL_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [tpl_pkg::TPL_DW-1:0] reg_rdata,
   // car controller channels
   input wire logic [tpl_pkg::TPL_W-1:0] serial_cmd,
   input wire logic serial_strobe,
   input wire logic [tpl_pkg::TPL_W-1:0] analog_cmd,
   input wire logic terminal_logic_input,
   // regulator side
   input wire logic reg_release,
   input wire logic [tpl_pkg::TPL_W-1:0] torque_prime_cmd,
   input wire logic torque_prime_apply,
   input wire logic torque_prime_held
);
   import tpl_pkg::*;
   // ---------------------------------
   // control shadow
   // ---------------------------------
   logic [3:0] ctrl_q; // mirror of the control fields, kept from port writes
   logic strb; // strobe picked by the mirrored selector
   assign strb = ctrl_q[3] ? terminal_logic_input : serial_strobe;
   // mirror follows writes at the edge they are taken
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ctrl_q <= 4'h8;
      else if (reg_wr && reg_addr == TPL_CTRL_OFS)
         ctrl_q <= reg_wdata[3:0];
   end
   // ---------------------------------
   // properties
   // ---------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // release seen low then high
   sequence s_release;
      !reg_release ##1 reg_release;
   endsequence
   a_apply_cause:
      assert property (torque_prime_apply |-> $past(reg_release) && !$past(reg_release, 2)
         && $past(ctrl_q[1:0]) != 2'h0)
      else $error("apply pulse without release edge");
   a_apply_single:
      assert property (torque_prime_apply |=> !torque_prime_apply)
      else $error("apply pulse longer than one cycle");
   a_none_quiet:
      assert property (s_release ##0 ctrl_q[1:0] == 2'h0 |=> !torque_prime_apply)
      else $error("apply with source none");
   // a capture on the release edge itself is kept, so held may stay up then
   a_latched_use:
      assert property (s_release ##0 (ctrl_q[2] && ctrl_q[1:0] != 2'h0)
         |=> torque_prime_apply && (!torque_prime_held || ($past(strb) && !$past(strb, 2))))
      else $error("latched release left value held");
   a_serial_live:
      assert property (s_release ##0 ctrl_q[2:0] == 3'h1
         |=> torque_prime_apply && torque_prime_cmd == $past(serial_cmd))
      else $error("live serial command not applied");
   a_cmd_steady:
      assert property (!torque_prime_apply |-> $stable(torque_prime_cmd))
      else $error("command moved without apply");
   a_capture_edge:
      assert property ($rose(torque_prime_held) |-> $past(ctrl_q[2]) && $past(strb)
         && !$past(strb, 2))
      else $error("capture without selected strobe edge");
   a_reset_empty:
      assert property ($rose(rstn) |-> !torque_prime_held && torque_prime_cmd == 16'h0000)
      else $error("held value survived reset");
endmodule
bind tpl_latch tpl_latch_asserts u_asserts (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .serial_cmd(serial_cmd), .serial_strobe(serial_strobe), .analog_cmd(analog_cmd),
   .terminal_logic_input(terminal_logic_input), .reg_release(reg_release),
   .torque_prime_cmd(torque_prime_cmd), .torque_prime_apply(torque_prime_apply),
   .torque_prime_held(torque_prime_held));

// File: verification/tpl_car.sv
`timescale 1ns/100ps
// car controller model: command channels and capture strobes
module tpl_car
(
   // clock
   input wire logic clk,
   // channels toward the drive
   output logic [tpl_pkg::TPL_W-1:0] serial_cmd,
   output logic serial_strobe,
   output logic [tpl_pkg::TPL_W-1:0] analog_cmd,
   output logic terminal_logic_input
);
   // quiet channels at time zero
   initial
   begin
      serial_cmd = 16'h0000;
      serial_strobe = 1'b0;
      analog_cmd = 16'h0000;
      terminal_logic_input = 1'b0;
   end
   // new values, then one settling edge for the analog scaler
   task automatic load(input logic [15:0] s, input logic [15:0] a);
      @(posedge clk);
      serial_cmd <= s;
      analog_cmd <= a;
      @(posedge clk);
   endtask
   // one strobe pulse; channels never move around the edge
   task automatic pulse(input bit term);
      @(posedge clk);
      // only the chosen strobe rises; the other stays low
      terminal_logic_input <= term;
      serial_strobe <= ~term;
      @(posedge clk);
      terminal_logic_input <= 1'b0;
      serial_strobe <= 1'b0;
      @(posedge clk);
   endtask
endmodule

// File: verification/tpl_latch_tb.sv
`timescale 1ns/100ps
// bench for the torque priming latch
module tpl_latch_tb;
   import tpl_pkg::*;
   logic clk;
   logic rstn;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [15:0] serial_cmd;
   logic serial_strobe;
   logic [15:0] analog_cmd;
   logic terminal_logic_input;
   logic reg_release;
   logic [15:0] torque_prime_cmd;
   logic torque_prime_apply;
   logic torque_prime_held;
   int num_errors = 0;
   int check_count = 0;
   logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
   logic [31:0] rv [6] = '{32'h8, 32'h100, 32'h0, 32'h0, 32'h0, 32'h0};
   tpl_latch DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_cmd(serial_cmd),
      .serial_strobe(serial_strobe), .analog_cmd(analog_cmd),
      .terminal_logic_input(terminal_logic_input), .reg_release(reg_release),
      .torque_prime_cmd(torque_prime_cmd), .torque_prime_apply(torque_prime_apply),
      .torque_prime_held(torque_prime_held));
   tpl_car car (.clk(clk), .serial_cmd(serial_cmd), .serial_strobe(serial_strobe),
      .analog_cmd(analog_cmd), .terminal_logic_input(terminal_logic_input));
   // 4 ns clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("read data", e, reg_rdata);
   endtask
   // release edge, bounded wait for the apply pulse
   task automatic rel(input logic [15:0] e, input bit want);
      int n;
      @(posedge clk);
      reg_release <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (torque_prime_apply !== 1'b1 && n < 4);
      chk("apply pulse", {31'h0, want}, {31'h0, torque_prime_apply === 1'b1});
      if (want && n == 4)
         close_out();
      if (want)
         chk("applied cmd", {16'h0, e}, {16'h0, torque_prime_cmd});
      @(posedge clk);
      reg_release <= 1'b0;
      @(posedge clk);
   endtask
   initial
   begin
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_release = 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++)
         rd(ra[i], rv[i]);
      $display("test reset values done");
      wr(TPL_CTRL_OFS, 32'h1);
      car.load(16'h1234, 16'h0000);
      rel(16'h1234, 1);
      wr(TPL_GAIN_OFS, 32'h0200);
      wr(TPL_BIAS_OFS, 32'h0010);
      rd(TPL_GAIN_OFS, 32'h0000_0200);
      rd(TPL_BIAS_OFS, 32'h0000_0010);
      wr(TPL_CTRL_OFS, 32'h2);
      car.load(16'h1234, 16'hFFF0);
      rel(16'hFFF0, 1);
      car.load(16'h1234, 16'h7000);
      rel(16'h7FFF, 1);
      $display("test live sources done");
      wr(TPL_CTRL_OFS, 32'hD);
      car.load(16'h0ABC, 16'h0000);
      car.pulse(1);
      car.load(16'h5555, 16'h0000);
      car.pulse(0);
      rd(TPL_HELD_OFS, 32'h0ABC);
      chk("held flag", 32'h1, {31'h0, torque_prime_held});
      rel(16'h0ABC, 1);
      rd(TPL_HELD_OFS, 32'h0);
      chk("held flag", 32'h0, {31'h0, torque_prime_held});
      wr(TPL_CTRL_OFS, 32'h5);
      car.load(16'h0777, 16'h0000);
      car.pulse(0);
      car.load(16'h1111, 16'h0000);
      car.pulse(1);
      rel(16'h0777, 1);
      // status: nothing held, latching in force, last command applied
      rd(TPL_STAT_OFS, 32'h0777_0002);
      $display("test latched capture done");
      wr(TPL_CTRL_OFS, 32'h4);
      car.load(16'h0999, 16'h0000);
      // the selected serial strobe rises, yet source none must ignore it
      car.pulse(0);
      chk("held flag", 32'h0, {31'h0, torque_prime_held});
      rel(16'h0000, 0);
      // latching not in force, last command untouched
      rd(TPL_STAT_OFS, 32'h0777_0000);
      $display("test source none done");
      wr(TPL_CTRL_OFS, 32'hD);
      car.pulse(1);
      rd(TPL_HELD_OFS, 32'h0999);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("held flag", 32'h0, {31'h0, torque_prime_held});
      chk("cmd in reset", 32'h0, {16'h0, torque_prime_cmd});
      @(posedge clk);
      rstn <= 1'b1;
      rd(TPL_HELD_OFS, 32'h0);
      rd(TPL_CTRL_OFS, 32'h8);
      $display("test mid reset done");
      close_out();
   end
endmodule
